// >>> verilog/fwsr_defines.svh
`ifndef FWSR_DEFINES_SVH
`define FWSR_DEFINES_SVH

// Register offsets, byte addresses on the APB side
`define FWSR_OFF_CTRL 12'h000
`define FWSR_OFF_ADDR 12'h004
`define FWSR_OFF_DATA 12'h008
`define FWSR_OFF_STATUS 12'h00c
`define FWSR_OFF_RDATA 12'h010
`define FWSR_OFF_SUSP 12'h014

// Control register fields
`define FWSR_CTRL_CMD_MSB 2
`define FWSR_CTRL_GO 3
`define FWSR_CTRL_AUTO 4
`define FWSR_CTRL_SKIP 5
`define FWSR_CTRL_TOGGLE 6
`define FWSR_CTRL_BUF 7

// Status register fields
`define FWSR_ST_BUSY 0
`define FWSR_ST_DONE 1
`define FWSR_ST_TIMEOUT 2
`define FWSR_ST_ABORT 3
`define FWSR_ST_REJECT 4
`define FWSR_ST_STARTED 5
`define FWSR_ST_REFUSED 6
`define FWSR_ST_RDYBSY 7
`define FWSR_ST_RECOVERED 8

// Suspended-sector register fields
`define FWSR_SUSP_VALID 8

// Command codes in the control register
`define FWSR_CMD_WRITE 3'h0
`define FWSR_CMD_READ 3'h1
`define FWSR_CMD_POLL 3'h2
`define FWSR_CMD_RESET 3'h3
`define FWSR_CMD_ABORT 3'h4
`define FWSR_CMD_ERASE 3'h5

// Status bit positions on the flash data bus
`define FWSR_DQ_POLLING 7
`define FWSR_DQ_TOGGLE1 6
`define FWSR_DQ_TIMEOUT 5
`define FWSR_DQ_TIMER 3
`define FWSR_DQ_TOGGLE2 2
`define FWSR_DQ_ABORT 1

// Flash command words and unlock addresses
`define FWSR_UNLOCK1_ADDR 12'h555
`define FWSR_UNLOCK2_ADDR 12'h2aa
`define FWSR_UNLOCK1_DATA 8'haa
`define FWSR_UNLOCK2_DATA 8'h55
`define FWSR_RESET_DATA 8'hf0
`define FWSR_SECTOR_ERASE_DATA 8'h30

// Sector field of the word address
`define FWSR_SECTOR_LSB 15

// Timing, figures in ns and derived cycle counts at the core clock rate
`define FWSR_CLK_MHZ 20
`define FWSR_T_ACC_NS 90
`define FWSR_T_WP_NS 35
`define FWSR_T_REC_NS 30
`define FWSR_ACC_CYC ((`FWSR_T_ACC_NS * `FWSR_CLK_MHZ + 999) / 1000)
`define FWSR_WP_CYC ((`FWSR_T_WP_NS * `FWSR_CLK_MHZ + 999) / 1000)
`define FWSR_REC_CYC ((`FWSR_T_REC_NS * `FWSR_CLK_MHZ + 999) / 1000)

`endif

// >>> verilog/fwsr_pkg.sv
package fwsr_pkg;

  // Sequencer states of the controller
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_LAUNCH, SEQ_WAIT, SEQ_EVAL} fwsr_seq_state_t;

  // States of a single flash bus cycle
  typedef enum logic [1:0] {CYC_IDLE, CYC_STROBE, CYC_RECOVER} fwsr_cyc_state_t;

endpackage : fwsr_pkg

// >>> verilog/fwsr_cyc_if.sv
`timescale 1ns/1ns
`default_nettype none

// One flash bus cycle: request from the sequencer, answer from the engine
interface fwsr_cyc_if #(
  parameter int AW = 23,
  parameter int DW = 16
);
  logic req; // One-cycle start pulse
  logic we; // High for a write cycle
  logic [AW-1:0] addr; // Word address
  logic [DW-1:0] wdata; // Data to write
  logic done; // One-cycle end pulse
  logic [DW-1:0] rdata; // Data sampled on a read

  modport seq (output req, output we, output addr, output wdata, input done, input rdata);
  modport eng (input req, input we, input addr, input wdata, output done, output rdata);
endinterface : fwsr_cyc_if

`default_nettype wire

// >>> verilog/fwsr_bus_cycle.sv
`timescale 1ns/1ns
`default_nettype none
`include "fwsr_defines.svh"

// Drives one asynchronous read or write cycle on the flash pins
module fwsr_bus_cycle #(
  parameter int AW = 23,
  parameter int DW = 16
) (
  input wire logic core_clk_in,
  input wire logic nrst_in,
  fwsr_cyc_if.eng cyc,
  input wire logic [DW-1:0] flash_dq_in,
  output logic [AW-1:0] flash_addr_out,
  output logic [DW-1:0] flash_dq_out,
  output logic flash_dq_oe_out,
  output logic flash_ce_n_out,
  output logic flash_oe_n_out,
  output logic flash_we_n_out
);

  fwsr_pkg::fwsr_cyc_state_t state; // Cycle phase
  logic [3:0] cnt; // Cycles left in the phase
  logic is_write; // Kind of the cycle under way

  // Cycle engine; every pin comes from a flop so no glitch reaches the flash
  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      state <= fwsr_pkg::CYC_IDLE;
      cnt <= 4'h0;
      is_write <= 1'b0;
      flash_addr_out <= '0;
      flash_dq_out <= '0;
      flash_dq_oe_out <= 1'b0;
      flash_ce_n_out <= 1'b1;
      flash_oe_n_out <= 1'b1;
      flash_we_n_out <= 1'b1;
      cyc.done <= 1'b0;
      cyc.rdata <= '0;
    end else begin
      cyc.done <= 1'b0;
      case (state)
        fwsr_pkg::CYC_IDLE: begin
          // Address, chip select and strobe go out together
          if (cyc.req) begin
            is_write <= cyc.we;
            flash_addr_out <= cyc.addr;
            flash_ce_n_out <= 1'b0;
            state <= fwsr_pkg::CYC_STROBE;
            if (cyc.we) begin
              flash_dq_out <= cyc.wdata;
              flash_dq_oe_out <= 1'b1;
              flash_we_n_out <= 1'b0;
              cnt <= 4'(`FWSR_WP_CYC - 1);
            end else begin
              flash_oe_n_out <= 1'b0;
              cnt <= 4'(`FWSR_ACC_CYC - 1);
            end
          end
        end
        fwsr_pkg::CYC_STROBE: begin
          // Hold the strobe for the whole access or pulse time
          if (cnt == 4'h0) begin
            if (!is_write) begin
              cyc.rdata <= flash_dq_in;
            end
            flash_oe_n_out <= 1'b1;
            flash_we_n_out <= 1'b1;
            flash_ce_n_out <= 1'b1;
            cnt <= 4'(`FWSR_REC_CYC - 1);
            state <= fwsr_pkg::CYC_RECOVER;
          end else begin
            cnt <= cnt - 4'h1;
          end
        end
        fwsr_pkg::CYC_RECOVER: begin
          // Write data stays driven past the strobe edge for hold time
          if (cnt == 4'h0) begin
            flash_dq_oe_out <= 1'b0;
            cyc.done <= 1'b1;
            state <= fwsr_pkg::CYC_IDLE;
          end else begin
            cnt <= cnt - 4'h1;
          end
        end
        default: begin
          state <= fwsr_pkg::CYC_IDLE;
        end
      endcase
    end
  end

endmodule : fwsr_bus_cycle

`default_nettype wire

// >>> verilog/fwsr_host.sv
// The placing of the registers and the APB slave port were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "fwsr_defines.svh"

// Summary of operation
// [RULE1] Timeout flag high means operation failed
// [RULE2] Programming one over zero ends in timeout
// [RULE3] After timeout send reset to recover
// [RULE4] Erase timer check only for sector erase
// [RULE5] Each extra sector command restarts window
// [RULE6] Timer bit zero while window open
// [RULE7] Fast hosts may skip timer bit checks
// [RULE8] Timer bit one: erase started, commands ignored
// [RULE9] Timer bit zero: extra sectors still accepted
// [RULE10] Check timer bit before and after command
// [RULE11] Abort bit set needs abort reset sequence; the abort bit is not checked when polling by toggle bit
// [RULE12] Poll at a valid, erasing sector address
// [RULE13] Buffered write polls last loaded address
// [RULE14] Never read the program-suspended sector
// [RULE15] Program busy shows complement of data
// [RULE16] Erase shows polling zero, both toggling
// [RULE17] Polling bit one once erase finishes
// [RULE18] First toggle bit flips each busy read
module fwsr_host #(
  parameter int AW = 23,
  parameter int DW = 16
) (
  input wire logic core_clk_in,
  input wire logic nrst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic [DW-1:0] flash_dq_in,
  input wire logic ready_busy_n_in,
  output logic [AW-1:0] flash_addr_out,
  output logic [DW-1:0] flash_dq_out,
  output logic flash_dq_oe_out,
  output logic flash_ce_n_out,
  output logic flash_oe_n_out,
  output logic flash_we_n_out
);

  localparam int SW = AW - `FWSR_SECTOR_LSB; // Sector number width

  fwsr_cyc_if #(.AW(AW), .DW(DW)) cyc ();

  fwsr_pkg::fwsr_seq_state_t state; // Sequencer state
  logic [2:0] cur_cmd; // Command under way
  logic [1:0] step; // Position inside a multi-cycle command
  logic recheck; // Timeout flag seen once, one more look due
  logic have_prev; // A toggle reference has been taken
  logic prev_toggle; // First toggle bit of the previous read
  logic ctrl_auto; // Recover by itself after a fault
  logic ctrl_skip; // Host spaces sector commands tightly
  logic ctrl_toggle; // Poll by toggle bit instead of polling bit
  logic ctrl_buf; // Poll belongs to a buffered write
  logic [AW-1:0] addr_reg; // Target or poll address
  logic [DW-1:0] data_reg; // Write data, or expected data for polling
  logic [DW-1:0] rdata_reg; // Last status or array word read
  logic [SW-1:0] susp_sector; // Sector held in program suspend
  logic susp_valid; // A program suspend is in force
  logic st_done; // Last command finished
  logic st_timeout; // Operation failed on time limit
  logic st_abort; // Buffered write aborted
  logic st_reject; // Extra sector command may be lost
  logic st_started; // Embedded erase has begun
  logic st_refused; // Command refused on suspended sector
  logic st_recovered; // Reset sequence was sent
  logic next_we; // Kind of the next flash cycle
  logic [AW-1:0] next_caddr; // Address of the next flash cycle
  logic [DW-1:0] next_cdata; // Data of the next flash cycle

  wire logic apb_access = psel_in & penable_in; // Access phase
  wire logic apb_commit = apb_access & pready_out; // Edge that completes it
  wire logic idle = (state == fwsr_pkg::SEQ_IDLE);
  wire logic ctrl_wr = apb_commit & pwrite_in & (paddr_in == `FWSR_OFF_CTRL) & idle;
  wire logic go = ctrl_wr & pwdata_in[`FWSR_CTRL_GO];
  wire logic [2:0] go_cmd = pwdata_in[`FWSR_CTRL_CMD_MSB:0];
  wire logic [DW-1:0] rd = cyc.rdata; // Word of the finished read
  wire logic sect_hit = (addr_reg[AW-1:`FWSR_SECTOR_LSB] == susp_sector);
  wire logic go_refused = susp_valid & sect_hit &
      ((go_cmd == `FWSR_CMD_READ) | (go_cmd == `FWSR_CMD_POLL) | (go_cmd == `FWSR_CMD_ERASE));
  wire logic poll_match = ctrl_toggle ? (rd[`FWSR_DQ_TOGGLE1] == prev_toggle) :
      (rd[`FWSR_DQ_POLLING] == data_reg[`FWSR_DQ_POLLING]);

  // Offset decode, used by the error answer and by the write path
  function automatic logic addr_hit(input logic [11:0] a);
    addr_hit = (a == `FWSR_OFF_CTRL) | (a == `FWSR_OFF_ADDR) | (a == `FWSR_OFF_DATA) |
        (a == `FWSR_OFF_STATUS) | (a == `FWSR_OFF_RDATA) | (a == `FWSR_OFF_SUSP);
  endfunction : addr_hit

  // Read data of each register; unmapped offsets read zero
  function automatic logic [31:0] read_mux(input logic [11:0] a);
    logic [31:0] v;
    v = 32'h0;
    case (a)
      `FWSR_OFF_CTRL: v = {24'h0, ctrl_buf, ctrl_toggle, ctrl_skip, ctrl_auto, 1'b0, cur_cmd};
      `FWSR_OFF_ADDR: v = 32'(addr_reg);
      `FWSR_OFF_DATA: v = 32'(data_reg);
      `FWSR_OFF_RDATA: v = 32'(rdata_reg);
      `FWSR_OFF_SUSP: begin
        v = 32'(susp_sector);
        v[`FWSR_SUSP_VALID] = susp_valid;
      end
      `FWSR_OFF_STATUS: begin
        v[`FWSR_ST_BUSY] = ~idle;
        v[`FWSR_ST_DONE] = st_done;
        v[`FWSR_ST_TIMEOUT] = st_timeout;
        v[`FWSR_ST_ABORT] = st_abort;
        v[`FWSR_ST_REJECT] = st_reject;
        v[`FWSR_ST_STARTED] = st_started;
        v[`FWSR_ST_REFUSED] = st_refused;
        v[`FWSR_ST_RDYBSY] = ready_busy_n_in;
        v[`FWSR_ST_RECOVERED] = st_recovered;
      end
      default: v = 32'h0;
    endcase
    read_mux = v;
  endfunction : read_mux

  // APB answer: one wait state, then ready with data and error flag
  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      pready_out <= 1'b0;
      prdata_out <= 32'h0;
      pslverr_out <= 1'b0;
    end else begin
      pready_out <= apb_access & ~pready_out;
      if (apb_access & ~pready_out) begin
        prdata_out <= pwrite_in ? 32'h0 : read_mux(paddr_in);
        pslverr_out <= ~addr_hit(paddr_in);
      end else begin
        prdata_out <= 32'h0;
        pslverr_out <= 1'b0;
      end
    end
  end

  // Software settings; ignored while a command runs so it sees one setup
  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      ctrl_auto <= 1'b0;
      ctrl_skip <= 1'b0;
      ctrl_toggle <= 1'b0;
      ctrl_buf <= 1'b0;
      addr_reg <= '0;
      data_reg <= '0;
      susp_sector <= '0;
      susp_valid <= 1'b0;
    end else if (apb_commit & pwrite_in & idle & addr_hit(paddr_in)) begin
      case (paddr_in)
        `FWSR_OFF_CTRL: begin
          ctrl_auto <= pwdata_in[`FWSR_CTRL_AUTO];
          ctrl_skip <= pwdata_in[`FWSR_CTRL_SKIP]; // RULE7
          ctrl_toggle <= pwdata_in[`FWSR_CTRL_TOGGLE];
          ctrl_buf <= pwdata_in[`FWSR_CTRL_BUF];
        end
        `FWSR_OFF_ADDR: addr_reg <= pwdata_in[AW-1:0]; // RULE12 RULE13
        `FWSR_OFF_DATA: data_reg <= pwdata_in[DW-1:0];
        `FWSR_OFF_SUSP: begin
          susp_sector <= pwdata_in[SW-1:0];
          susp_valid <= pwdata_in[`FWSR_SUSP_VALID];
        end
        default: begin
          susp_valid <= susp_valid;
        end
      endcase
    end
  end

  // Shape of the next flash cycle for the command and step under way
  always_comb begin
    next_we = 1'b0;
    next_caddr = addr_reg;
    next_cdata = data_reg;
    case (cur_cmd)
      `FWSR_CMD_WRITE: next_we = 1'b1;
      `FWSR_CMD_RESET: begin
        next_we = 1'b1; // RULE3
        next_caddr = AW'(`FWSR_UNLOCK1_ADDR);
        next_cdata = DW'(`FWSR_RESET_DATA);
      end
      `FWSR_CMD_ABORT: begin
        next_we = 1'b1; // RULE11
        next_caddr = (step == 2'h1) ? AW'(`FWSR_UNLOCK2_ADDR) : AW'(`FWSR_UNLOCK1_ADDR);
        case (step)
          2'h0: next_cdata = DW'(`FWSR_UNLOCK1_DATA);
          2'h1: next_cdata = DW'(`FWSR_UNLOCK2_DATA);
          default: next_cdata = DW'(`FWSR_RESET_DATA);
        endcase
      end
      `FWSR_CMD_ERASE: begin
        // Extra sector command is the bare confirm word inside the window
        next_we = (step == 2'h1); // RULE5 RULE9
        next_cdata = DW'(`FWSR_SECTOR_ERASE_DATA);
      end
      default: next_we = 1'b0;
    endcase
  end

  // Command sequencer and the sticky result flags; flags clear only at go,
  // which is taken while idle, so no set can meet a clear
  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      state <= fwsr_pkg::SEQ_IDLE;
      cur_cmd <= `FWSR_CMD_WRITE;
      step <= 2'h0;
      recheck <= 1'b0;
      have_prev <= 1'b0;
      prev_toggle <= 1'b0;
      rdata_reg <= '0;
      st_done <= 1'b0;
      st_timeout <= 1'b0;
      st_abort <= 1'b0;
      st_reject <= 1'b0;
      st_started <= 1'b0;
      st_refused <= 1'b0;
      st_recovered <= 1'b0;
      cyc.req <= 1'b0;
      cyc.we <= 1'b0;
      cyc.addr <= '0;
      cyc.wdata <= '0;
    end else begin
      cyc.req <= 1'b0;
      case (state)
        fwsr_pkg::SEQ_IDLE: begin
          if (ctrl_wr) begin
            cur_cmd <= go_cmd;
          end
          if (go) begin
            st_done <= go_refused; // RULE14
            st_refused <= go_refused; // RULE14
            st_timeout <= 1'b0;
            st_abort <= 1'b0;
            st_reject <= 1'b0;
            st_started <= 1'b0;
            st_recovered <= 1'b0;
            recheck <= 1'b0;
            have_prev <= 1'b0;
            // Tight spacing skips the check before the extra sector command
            step <= ((go_cmd == `FWSR_CMD_ERASE) & pwdata_in[`FWSR_CTRL_SKIP]) ? 2'h1 : 2'h0;
            if (!go_refused) begin
              state <= fwsr_pkg::SEQ_LAUNCH;
            end
          end
        end
        fwsr_pkg::SEQ_LAUNCH: begin
          cyc.req <= 1'b1;
          cyc.we <= next_we;
          cyc.addr <= next_caddr;
          cyc.wdata <= next_cdata;
          state <= fwsr_pkg::SEQ_WAIT;
        end
        fwsr_pkg::SEQ_WAIT: begin
          if (cyc.done) begin
            state <= fwsr_pkg::SEQ_EVAL;
          end
        end
        fwsr_pkg::SEQ_EVAL: begin
          state <= fwsr_pkg::SEQ_IDLE;
          case (cur_cmd)
            `FWSR_CMD_READ: begin
              rdata_reg <= rd;
              st_done <= 1'b1;
            end
            `FWSR_CMD_RESET: begin
              st_recovered <= 1'b1; // RULE3
              st_done <= 1'b1;
            end
            `FWSR_CMD_ABORT: begin
              if (step == 2'h2) begin
                st_recovered <= 1'b1; // RULE11
                st_done <= 1'b1;
              end else begin
                step <= step + 2'h1;
                state <= fwsr_pkg::SEQ_LAUNCH;
              end
            end
            `FWSR_CMD_ERASE: begin
              if (step != 2'h1) begin
                rdata_reg <= rd;
              end
              if ((step != 2'h1) & rd[`FWSR_DQ_TIMER]) begin
                // Window closed: erase runs and the command is not sent or lost
                st_started <= 1'b1; // RULE6 RULE8
                st_reject <= 1'b1; // RULE10
                st_done <= 1'b1;
              end else if ((step == 2'h2) | ((step == 2'h1) & ctrl_skip)) begin
                st_done <= 1'b1; // RULE7
              end else begin
                step <= step + 2'h1; // RULE4 RULE10
                state <= fwsr_pkg::SEQ_LAUNCH;
              end
            end
            `FWSR_CMD_POLL: begin
              rdata_reg <= rd;
              prev_toggle <= rd[`FWSR_DQ_TOGGLE1];
              have_prev <= 1'b1;
              if (ctrl_toggle & !have_prev) begin
                state <= fwsr_pkg::SEQ_LAUNCH; // RULE18
              end else if (poll_match) begin
                // Data matches, or toggling stopped: the operation is over
                st_done <= 1'b1; // RULE15 RULE16 RULE17 RULE18
              end else if (recheck | (ctrl_buf & !ctrl_toggle & rd[`FWSR_DQ_ABORT])) begin
                st_timeout <= recheck; // RULE1 RULE2
                st_abort <= ~recheck; // RULE11
                if (ctrl_auto) begin
                  cur_cmd <= recheck ? `FWSR_CMD_RESET : `FWSR_CMD_ABORT; // RULE3 RULE11
                  step <= 2'h0;
                  state <= fwsr_pkg::SEQ_LAUNCH;
                end else begin
                  st_done <= 1'b1;
                end
              end else begin
                // Status may settle as the timeout flag rises, so look once more
                recheck <= rd[`FWSR_DQ_TIMEOUT]; // RULE1
                state <= fwsr_pkg::SEQ_LAUNCH;
              end
            end
            default: begin
              st_done <= 1'b1;
            end
          endcase
        end
        default: begin
          state <= fwsr_pkg::SEQ_IDLE;
        end
      endcase
    end
  end

  // Pin engine; the sequencer waits on its done pulse, never on a count
  fwsr_bus_cycle #(.AW(AW), .DW(DW)) u_cycle (
    .core_clk_in(core_clk_in),
    .nrst_in(nrst_in),
    .cyc(cyc.eng),
    .flash_dq_in(flash_dq_in),
    .flash_addr_out(flash_addr_out),
    .flash_dq_out(flash_dq_out),
    .flash_dq_oe_out(flash_dq_oe_out),
    .flash_ce_n_out(flash_ce_n_out),
    .flash_oe_n_out(flash_oe_n_out),
    .flash_we_n_out(flash_we_n_out)
  );

endmodule : fwsr_host

`default_nettype wire

// >>> tb/fwsr_flash_model.sv
`timescale 1ns/1ns
`default_nettype none

// Flash status behaviour; st: 0 ready, 1 program, 2 timeout, 3 abort, 4 window, 5 erase, 6 susp
module fwsr_flash_model (
  input wire logic clk_in,
  input wire logic ce_n_in,
  input wire logic oe_n_in,
  input wire logic we_n_in,
  input wire logic [22:0] addr_in,
  input wire logic [15:0] dq_in,
  input wire logic dq_oe_in,
  output logic [15:0] dq_out,
  output logic ready_busy_n_out
);
  int st = 0; // Current mode
  int left = 0; // Reads until the mode moves on
  int win = 4; // Window length in reads
  int reads = 0; // Read cycles seen
  int writes = 0; // Write cycles seen
  logic w7 = 1'b0; // Bit 7 of the array word
  logic tg = 1'b0; // Toggle source
  int seq = 0; // Unlock progress of abort reset
  logic [15:0] rd = 16'h0000; // Word on the bus
  logic ract = 1'b0;
  logic wact = 1'b0;
  logic [15:0] s;
  // Released bus shows inverse of last word, so a stale value cannot pass
  assign dq_out = dq_oe_in ? dq_in : ((!ce_n_in && !oe_n_in) ? rd : ~rd);
  assign ready_busy_n_out = (st == 0 || st == 6);
  // Pins are sampled on the clock to avoid strobe races
  always @(posedge clk_in) begin
    ract <= !ce_n_in && !oe_n_in;
    wact <= !ce_n_in && !we_n_in;
    if (!ce_n_in && !oe_n_in && !ract) begin
      reads++;
      s = {8'h5a, w7, addr_in[6:0]};
      case (st)
        1, 2, 3: s[7:0] = {~w7, tg, st == 2, 3'h0, st == 3, 1'b0};
        4, 5: s[7:0] = {1'b0, tg, 2'h0, st == 5, tg, 2'h0};
        6: s[7:0] = {2'h2, 3'h0, tg, 2'h0};
        default: ;
      endcase
      rd <= s;
      tg <= ~tg;
      // Program, window and erase modes count down; window expiry starts the erase
      if (st == 1 || st == 4 || st == 5) begin
        left--;
        if (left <= 0) begin
          st = (st == 4) ? 5 : 0;
          left = win;
        end
      end
    end
    if (!ce_n_in && !we_n_in && !wact) begin
      writes++;
      if (dq_in[7:0] == 8'hf0 && (st == 2 || (st == 3 && seq == 2))) st = 0;
      if (dq_in[7:0] == 8'h30 && st == 4) left = win;
      seq = (dq_in[7:0] == 8'haa) ? 1 : ((dq_in[7:0] == 8'h55 && seq == 1) ? 2 : 0);
    end
  end
endmodule : fwsr_flash_model

`default_nettype wire

// >>> tb/fwsr_host_asserts.sv
`timescale 1ns/1ns
`default_nettype none

module fwsr_host_asserts #(
  parameter int AW = 23
) (
  input wire logic core_clk_in,
  input wire logic nrst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire logic [AW-1:0] flash_addr_out,
  input wire logic flash_dq_oe_out,
  input wire logic flash_ce_n_out,
  input wire logic flash_oe_n_out,
  input wire logic flash_we_n_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!nrst_in);
  a_ready_pulse: assert property (pready_out |=> !pready_out) else $error("ready too long");
  a_one_wait: assert property (psel_in && penable_in && !pready_out |=> pready_out)
    else $error("ready late");
  a_ready_cause: assert property (pready_out |-> $past(psel_in && penable_in))
    else $error("ready without access");
  a_unmapped_err: assert property (pready_out && paddr_in > 12'h014 |-> pslverr_out)
    else $error("no error on unmapped");
  a_idle_rdata: assert property (!pready_out |-> prdata_out == 32'h0) else $error("rdata leak");
  a_read_width: assert property ($fell(flash_oe_n_out) |=> !flash_oe_n_out ##1 flash_oe_n_out)
    else $error("read strobe width");
  a_write_width: assert property ($fell(flash_we_n_out) |=> flash_we_n_out)
    else $error("write strobe width");
  a_no_clash: assert property (!flash_oe_n_out |-> !flash_dq_oe_out && flash_we_n_out)
    else $error("bus contention");
  a_write_drive: assert property (!flash_we_n_out |-> flash_dq_oe_out && !flash_ce_n_out)
    else $error("write not driven");
  a_addr_steady: assert property (!flash_oe_n_out && $past(!flash_oe_n_out) |-> $stable(flash_addr_out))
    else $error("address moved in read");
  c_read: cover property ($fell(flash_oe_n_out));
  c_write: cover property ($fell(flash_we_n_out));
  c_err: cover property (pready_out && pslverr_out);
endmodule : fwsr_host_asserts

bind fwsr_host fwsr_host_asserts #(.AW(AW)) i_fwsr_host_asserts (.core_clk_in(core_clk_in),
  .nrst_in(nrst_in), .psel_in(psel_in), .penable_in(penable_in), .paddr_in(paddr_in),
  .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
  .flash_addr_out(flash_addr_out), .flash_dq_oe_out(flash_dq_oe_out),
  .flash_ce_n_out(flash_ce_n_out), .flash_oe_n_out(flash_oe_n_out),
  .flash_we_n_out(flash_we_n_out));

`default_nettype wire

// >>> tb/tb_fwsr_host.sv
`timescale 1ns/1ns
`default_nettype none
`include "fwsr_defines.svh"

module tb_fwsr_host;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [15:0] dq_i;
  logic rbn;
  logic [22:0] fa;
  logic [15:0] fd;
  logic foe;
  logic ce;
  logic oe;
  logic we;
  logic [31:0] r; // Last read word
  logic e; // Last error flag
  int fails = 0;
  int num_checks = 0;
  int cyc = 0;
  int n0;
  fwsr_host i_fwsr_host (.core_clk_in(clk), .nrst_in(nrst), .psel_in(psel), .penable_in(pen),
    .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .flash_dq_in(dq_i), .ready_busy_n_in(rbn),
    .flash_addr_out(fa), .flash_dq_out(fd), .flash_dq_oe_out(foe), .flash_ce_n_out(ce),
    .flash_oe_n_out(oe), .flash_we_n_out(we));
  fwsr_flash_model m (.clk_in(clk), .ce_n_in(ce), .oe_n_in(oe), .we_n_in(we), .addr_in(fa),
    .dq_in(fd), .dq_oe_in(foe), .dq_out(dq_i), .ready_busy_n_out(rbn));
  initial forever #25 clk = ~clk;
  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      fails++;
      give_verdict;
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  // One APB transfer; holds the request until ready is sampled
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb
  // Launch a command and poll status until done
  task automatic run(input logic [22:0] a, input logic [31:0] d, input logic [31:0] ctl);
    int n;
    n = 0;
    apb(1'b1, `FWSR_OFF_ADDR, {9'h0, a});
    apb(1'b1, `FWSR_OFF_DATA, d);
    apb(1'b1, `FWSR_OFF_CTRL, ctl | 32'h8);
    do begin
      apb(1'b0, `FWSR_OFF_STATUS, 32'h0);
      n++;
    end while (r[1] !== 1'b1 && n < 200);
    // A command that never finishes is a failure, not a silent pass
    if (r[1] !== 1'b1) fails++;
  endtask : run
  task automatic t_regs;
    apb(1'b0, 12'h018, 32'h0);
    check({31'h0, e}, 32'h1);
    apb(1'b1, `FWSR_OFF_CTRL, 32'h51);
    apb(1'b0, `FWSR_OFF_CTRL, 32'h0);
    check(r, 32'h51);
  endtask : t_regs
  task automatic t_prog;
    for (int t = 0; t < 2; t++) begin
      m.st = 1;
      m.left = 3;
      m.w7 = 1'b1;
      n0 = m.reads;
      run(23'h000123, 32'h80, {25'h0, t[0], 6'h02});
      check(r[2], 1'b0);
      check(m.st, 0);
      if (t == 0) check(m.reads - n0, 4);
    end
    run(23'h000123, 32'h0, 32'h1);
    apb(1'b0, `FWSR_OFF_RDATA, 32'h0);
    check(r, 32'h5aa3);
  endtask : t_prog
  task automatic t_fault;
    for (int i = 0; i < 2; i++) begin
      m.st = 2 + i;
      run(23'h000010, 32'h80, 32'h12 | (i << 7));
      check(r[2 + i], 1'b1);
      check(r[8], 1'b1);
      check(m.st, 0);
    end
  endtask : t_fault
  task automatic t_erase;
    m.st = 4;
    m.left = 4;
    n0 = m.writes;
    run(23'h018000, 32'hff, 32'h5);
    check(r[5:4], 2'h0);
    check(m.left, 3);
    check(m.writes - n0, 1);
    m.st = 5;
    m.left = 2;
    run(23'h018000, 32'hff, 32'h5);
    check(r[5:4], 2'h3);
    check(m.writes - n0, 1);
    run(23'h018000, 32'hff, 32'h2);
    check(r[2], 1'b0);
    check(m.st, 0);
    // Tight spacing: confirm word only, no timer reads around it
    m.st = 4;
    m.left = 4;
    n0 = m.writes;
    run(23'h018000, 32'hff, 32'h25);
    check(m.writes - n0, 1);
    check(m.left, 4);
    check(r[5:4], 2'h0);
    // Raw write of the reset word clears a timed-out operation
    m.st = 2;
    run(23'h000555, 32'hf0, 32'h0);
    check(m.st, 0);
  endtask : t_erase
  task automatic t_susp;
    apb(1'b1, `FWSR_OFF_SUSP, 32'h103);
    n0 = m.reads;
    run(23'h018005, 32'h0, 32'h1);
    check(r[6], 1'b1);
    check(m.reads - n0, 0);
    check(r[7], 1'b1);
  endtask : t_susp
  task automatic give_verdict;
    if (fails == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : give_verdict
  initial begin
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    t_regs;
    t_prog;
    t_fault;
    t_erase;
    t_susp;
    give_verdict;
  end
endmodule : tb_fwsr_host

`default_nettype wire
